// [verilog/cfg_access_pkg.sv]
// Constants for the configuration port unlock and register bank
package cfg_access_pkg;
    localparam int ADDR_W = 10;
    localparam int NUM_REGS = 42;
    localparam logic [9:0] BASE_STRAP_LOW = 10'h3F0;
    localparam logic [9:0] BASE_STRAP_HIGH = 10'h370;
    localparam logic [7:0] KEY_UNLOCK = 8'h55;
    localparam logic [7:0] KEY_EXIT = 8'hAA;
    localparam logic [7:0] LAST_REG = 8'h29;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam int IDX_DEV_ID = 13;
    localparam int IDX_DEV_REV = 14;
    localparam logic STRAP_RESET = 1'b0;
    // Power-up values of the configuration registers except 13 and 14 (DEV_ID, DEV_REV), by register number
    localparam logic [7:0] CFG_DEFAULT [0:NUM_REGS-1] = '{
        8'h28, 8'h9C, 8'h88, 8'h78, 8'h00, 8'h00, 8'hFF, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h00,
        8'h3C, 8'h3C, 8'h3D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00
    };
    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00,
        ST_ARMED = 2'b01,
        ST_CONFIG = 2'b10
    } unlock_state_t;
endpackage

// [verilog/cfg_reg_cell.sv]
// One configuration register byte, set to RESET_VAL only by power-on reset
`timescale 1ns/100ps
`default_nettype none
module cfg_reg_cell #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter bit WRITABLE = 1'b1
) (
    input wire logic clk_sys,
    input wire logic por,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    logic [7:0] value_q;
    logic [7:0] value_d;

    // Next value: take host data on a qualified write
    always_comb begin
        value_d = value_q;
        if (WRITABLE && wr_en) begin
            value_d = wr_data;
        end
    end

    // Storage survives hardware reset; only power-on restores default
    always_ff @(posedge clk_sys or posedge por) begin
        if (por) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule
`default_nettype wire

// [verilog/cfg_port_access.sv]
// Configuration index/data port pair with key-sequence unlock
// Contract
// - Strap latched at reset release picks base 3F0H (low) or 370H (high).
// - After power-up the block runs defaults; after hardware reset it stays outside configuration mode.
// - Two back-to-back writes of 55H to index port enter configuration mode.
// - Any other write between the two unlock writes aborts the sequence.
// - In configuration mode index selects register 0-29H reached at data port.
// - Writing AAH to index port in configuration mode locks access again.
// - Registers load defaults at power-up and survive hardware reset.
`timescale 1ns/100ps
`default_nettype none
module cfg_port_access #(
    parameter logic [7:0] DEV_ID = 8'h5A, // Arbitrary identification value
    parameter logic [7:0] DEV_REV = 8'h01 // Arbitrary revision value
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic por,
    input wire logic modem_handshake_strap_pin,
    input wire logic io_wr_stb,
    input wire logic io_rd_stb,
    input wire logic [cfg_access_pkg::ADDR_W-1:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rd_ack,
    output logic config_mode,
    output logic base_is_high,
    output logic [cfg_access_pkg::NUM_REGS*8-1:0] config_regs
);
    import cfg_access_pkg::*;

    logic strap_s1_q;
    logic strap_s2_q;
    logic rst_seen_q;
    logic rst_seen_d;
    logic strap_q;
    logic strap_d;
    unlock_state_t state_q;
    unlock_state_t state_d;
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rd_ack_q;
    logic rd_ack_d;
    logic [9:0] index_addr;
    logic [9:0] data_addr;
    logic idx_hit;
    logic data_hit;
    logic cfg_mode;
    logic cfg_wr;
    logic [NUM_REGS-1:0][7:0] cfg_q;
    logic [7:0] rd_mux;

    // Strap pin synchroniser; runs through reset so the pin level is settled at release
    always_ff @(posedge clk_sys) begin
        strap_s1_q <= modem_handshake_strap_pin;
        strap_s2_q <= strap_s1_q; // Only this stage is read
    end

    // Catch the strap on the first edge after reset release
    always_comb begin
        rst_seen_d = 1'b0;
        strap_d = strap_q;
        if (rst_seen_q) begin
            strap_d = strap_s2_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_seen_q <= 1'b1;
            strap_q <= STRAP_RESET;
        end else begin
            rst_seen_q <= rst_seen_d;
            strap_q <= strap_d;
        end
    end

    // Port pair decode from the latched strap
    assign index_addr = strap_q ? BASE_STRAP_HIGH : BASE_STRAP_LOW;
    assign data_addr = index_addr + 10'h001;
    assign idx_hit = (io_addr == index_addr);
    assign data_hit = (io_addr == data_addr);
    assign cfg_mode = (state_q == ST_CONFIG);
    assign cfg_wr = cfg_mode && io_wr_stb && data_hit && (index_q <= LAST_REG);

    // Unlock sequencer and index register
    always_comb begin
        state_d = state_q;
        index_d = index_q;
        case (state_q)
            ST_LOCKED: begin
                if (io_wr_stb && idx_hit && io_wdata == KEY_UNLOCK) begin
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (io_wr_stb) begin
                    if (idx_hit && io_wdata == KEY_UNLOCK) begin
                        state_d = ST_CONFIG;
                    end else begin
                        state_d = ST_LOCKED;
                    end
                end
            end
            ST_CONFIG: begin
                if (io_wr_stb && idx_hit) begin
                    if (io_wdata == KEY_EXIT) begin
                        state_d = ST_LOCKED;
                    end else begin
                        index_d = io_wdata;
                    end
                end
            end
            default: begin
                state_d = ST_LOCKED;
            end
        endcase
    end

    // Hardware reset drops back to locked; register contents are untouched
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_LOCKED;
            index_q <= INDEX_RESET;
        end else begin
            state_q <= state_d;
            index_q <= index_d;
        end
    end

    // Configuration register bank, one cell per register number
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_cell
        localparam logic [7:0] RV = (i == IDX_DEV_ID) ? DEV_ID :
            (i == IDX_DEV_REV) ? DEV_REV : CFG_DEFAULT[i];
        cfg_reg_cell #(
            .RESET_VAL(RV),
            .WRITABLE((i != IDX_DEV_ID) && (i != IDX_DEV_REV))
        ) u_cell (
            .clk_sys(clk_sys),
            .por(por),
            .wr_en(cfg_wr && (index_q == 8'(i))),
            .wr_data(io_wdata),
            .value(cfg_q[i])
        );
        assign config_regs[i*8 +: 8] = cfg_q[i];
    end

    // Read mux: register behind the index, zero beyond the last one
    assign rd_mux = (index_q <= LAST_REG) ? cfg_q[index_q[5:0]] : READ_IDLE;

    // Read answer one cycle after the strobe, only in configuration mode
    always_comb begin
        rd_ack_d = 1'b0;
        rdata_d = READ_IDLE;
        if (io_rd_stb && cfg_mode) begin
            if (data_hit) begin
                rd_ack_d = 1'b1;
                rdata_d = rd_mux;
            end else if (idx_hit) begin
                rd_ack_d = 1'b1;
                rdata_d = index_q;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ack_q <= 1'b0;
            rdata_q <= READ_IDLE;
        end else begin
            rd_ack_q <= rd_ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign io_rdata = rdata_q;
    assign io_rd_ack = rd_ack_q;
    assign config_mode = cfg_mode;
    assign base_is_high = strap_q;

    property p_strap_latch;
        @(posedge clk_sys) disable iff (rst)
        rst_seen_q |=> (strap_q == $past(modem_handshake_strap_pin, 3))
            ##1 $stable(strap_q) ##1 $stable(strap_q);
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("strap not latched");

    property p_locked_after_reset;
        @(posedge clk_sys) disable iff (rst)
        rst_seen_q |-> !cfg_mode ##1 !cfg_mode;
    endproperty
    a_locked_after_reset: assert property (p_locked_after_reset) else $error("unlocked");

    property p_enter_needs_keys;
        @(posedge clk_sys) disable iff (rst)
        $rose(cfg_mode) |-> $past(state_q) == ST_ARMED && $past(io_wr_stb)
            && $past(idx_hit) && $past(io_wdata) == KEY_UNLOCK;
    endproperty
    a_enter_needs_keys: assert property (p_enter_needs_keys) else $error("bad entry");

    property p_break_sequence;
        @(posedge clk_sys) disable iff (rst)
        (state_q == ST_ARMED && io_wr_stb && !(idx_hit && io_wdata == KEY_UNLOCK))
            |=> state_q == ST_LOCKED ##1 !cfg_mode;
    endproperty
    a_break_sequence: assert property (p_break_sequence) else $error("no abort");

    property p_data_write;
        @(posedge clk_sys) disable iff (rst || por)
        (cfg_wr && index_q != 8'(IDX_DEV_ID) && index_q != 8'(IDX_DEV_REV))
            |=> cfg_q[$past(index_q[5:0])] == $past(io_wdata);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_data_read;
        @(posedge clk_sys) disable iff (rst)
        (io_rd_stb && cfg_mode && data_hit) |=> io_rd_ack && io_rdata == $past(rd_mux);
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read wrong");

    property p_exit;
        @(posedge clk_sys) disable iff (rst)
        (cfg_mode && io_wr_stb && idx_hit && io_wdata == KEY_EXIT)
            |=> !cfg_mode && $stable(index_q);
    endproperty
    a_exit: assert property (p_exit) else $error("exit failed");

    property p_keep_through_reset;
        @(posedge clk_sys) disable iff (por)
        rst |=> $stable(cfg_q);
    endproperty
    a_keep_through_reset: assert property (p_keep_through_reset) else $error("reset hit");

    property p_locked_no_write;
        @(posedge clk_sys) disable iff (rst || por)
        !cfg_mode |=> $stable(cfg_q);
    endproperty
    a_locked_no_write: assert property (p_locked_no_write) else $error("locked write");
endmodule
`default_nettype wire

// [testbench/host_io_model.sv]
// Host processor model issuing I/O port read and write cycles
`timescale 1ns/100ps
`default_nettype none
module host_io_model (
    input wire logic clk_sys,
    output logic io_wr_stb,
    output logic io_rd_stb,
    output logic [9:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rd_ack
);
    // Idle bus at time zero
    initial begin
        io_wr_stb = 1'b0;
        io_rd_stb = 1'b0;
        io_addr = 10'h000;
        io_wdata = 8'h00;
    end

    // One write; released lines show the inverse of the last value
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        io_wr_stb <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk_sys);
        io_wr_stb <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
        #1; // Let the write settle before the caller looks
    endtask

    // One read; data and claim are taken while the one-cycle answer stands
    task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic k);
        @(posedge clk_sys);
        io_rd_stb <= 1'b1;
        io_addr <= a;
        @(posedge clk_sys);
        io_rd_stb <= 1'b0;
        io_addr <= ~a;
        #1;
        d = io_rdata;
        k = io_rd_ack;
    endtask

    // Key pair with no other access between the two writes
    task automatic unlock(input logic [9:0] b);
        wr(b, 8'h55);
        wr(b, 8'h55);
    endtask
endmodule
`default_nettype wire

// [testbench/config_port_access_unlock_tb.sv]
// Self-checking bench for the configuration port unlock block
`timescale 1ns/100ps
`default_nettype none
module config_port_access_unlock_tb;
    import cfg_access_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic strap = 1'b0;
    logic io_wr_stb, io_rd_stb, io_rd_ack, config_mode, base_is_high, k;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata, d;
    logic [NUM_REGS*8-1:0] config_regs;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    cfg_port_access dut (.clk_sys(clk_sys), .rst(rst), .por(por),
        .modem_handshake_strap_pin(strap), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
        .config_mode(config_mode), .base_is_high(base_is_high), .config_regs(config_regs));
    host_io_model host (.clk_sys(clk_sys), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // Compare and count
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hold reset five cycles with the strap steady around release
    task automatic do_reset(input logic s, input logic p);
        @(posedge clk_sys);
        strap <= s;
        rst <= 1'b1;
        por <= p;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        por <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // Locked after power-up; data port writes and reads have no effect
    task automatic t_defaults();
        chk("mode", config_mode, 8'h00);
        chk("base", base_is_high, 8'h00);
        chk("reg0", config_regs[7:0], 8'h28);
        host.wr(10'h3F1, 8'h11);
        chk("reg0 locked", config_regs[7:0], 8'h28);
        host.rd(10'h3F1, d, k);
        chk("locked ack", k, 8'h00);
        chk("locked data", d, READ_IDLE);
    endtask

    // Unlock, load index, program register 1 and the last register, exit
    task automatic t_program();
        host.unlock(10'h3F0);
        chk("mode on", config_mode, 8'h01);
        host.wr(10'h3F0, 8'h01);
        host.wr(10'h3F1, 8'h9F);
        chk("reg1", config_regs[15:8], 8'h9F);
        host.rd(10'h3F1, d, k);
        chk("rd ack", k, 8'h01);
        chk("rd data", d, 8'h9F);
        host.rd(10'h3F0, d, k);
        chk("index rd", d, 8'h01);
        host.wr(10'h3F0, LAST_REG);
        host.wr(10'h3F1, 8'hC3);
        chk("reg29", config_regs[335:328], 8'hC3);
        host.wr(10'h3F0, 8'hAA);
        chk("mode off", config_mode, 8'h00);
        host.wr(10'h3F1, 8'h00);
        chk("reg1 locked", config_regs[15:8], 8'h9F);
    endtask

    // A write between the keys aborts; a read between them does not
    task automatic t_abort();
        host.wr(10'h3F0, 8'h55);
        host.wr(10'h3F1, 8'h00);
        host.wr(10'h3F0, 8'h55);
        chk("abort", config_mode, 8'h00);
        host.wr(10'h3F1, 8'h00);
        host.wr(10'h3F0, 8'h55);
        host.rd(10'h3F0, d, k);
        chk("armed ack", k, 8'h00);
        host.wr(10'h3F0, 8'h55);
        chk("read between", config_mode, 8'h01);
        host.wr(10'h3F0, 8'hAA);
    endtask

    // Strap high moves the ports; registers survive hardware reset
    task automatic t_strap();
        do_reset(1'b1, 1'b0);
        chk("base hi", base_is_high, 8'h01);
        chk("mode rst", config_mode, 8'h00);
        chk("reg1 kept", config_regs[15:8], 8'h9F);
        host.unlock(10'h3F0);
        chk("old base", config_mode, 8'h00);
        host.unlock(10'h370);
        chk("new base", config_mode, 8'h01);
        host.wr(10'h370, 8'hAA);
        chk("exit hi", config_mode, 8'h00);
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        do_reset(1'b0, 1'b1);
        t_defaults();
        t_program();
        t_abort();
        t_strap();
        print_verdict();
    end
endmodule
`default_nettype wire
